// [src/infoframe_readback_bank.sv]
// Purpose: Bank of captured infoframe fields over AHB-Lite, read-only except the interrupt status and mask
// Assumes: Packet parser on the same clock delivers one-cycle pulses
// Notes:   Zero wait states; all responses OKAY
//
// Summary of operation
// RL1: Flag bits 3, 4, 5 and 6 mark MPEG source, ACP, ISRC1, ISRC2 change.
// RL2: Flag bits 0, 1, 2 mark video, audio, source-description change; all copies match and any read clears them.
// RL3: Index 0x88 reads the upper byte of the top bar end; 0x86 the lower.
// RL4: The top bar end is the last line of the top bar, zero for none.
// RL5: Indices 0x89 and 0x8A read the 16-bit bottom bar start line.
// RL6: Software treats a bottom bar start beyond the active lines as none.
// RL7: Indices 0x8B and 0x8C read the 16-bit left pillar end, zero for none.
// RL8: Indices 0x8D and 0x8E read the 16-bit right pillar start.
// RL9: Index 0x8F reads the seven flags in bits 6 to 0, same as every copy.
// RL10: Bits 7 to 4 of index 0x91 read the audio coding kind.
// RL11: Bits 2 to 0 of index 0x91 read the audio channel code.
// RL12: Host writes leave the captured fields alone; unused bits read zero.
// RL13: All bytes of a multi-byte field come from the same packet.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module infoframe_readback_bank
    import infoframe_readback_pkg::*;
(
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic [31:0]                   hwdata,
    input  wire logic                          hready,
    output logic [31:0]                        hrdata,
    output logic                               hreadyout,
    output logic                               hresp,
    input  wire logic                          aviValid,
    input  wire infoframe_readback_pkg::bars_t  aviIn,
    input  wire logic                          audValid,
    input  wire infoframe_readback_pkg::audio_t audIn,
    input  wire logic [6:0]                    changeEvt,
    output logic                               irq
);
    import infoframe_readback_pkg::*;

    // ==========================================================
    // State and decode
    state_t      st_reg;
    state_t      st_next;
    logic        accept;
    logic [9:0]  idx;
    logic        flagRead;
    logic [6:0]  setEvt;

    // Address phase taken on a selected NONSEQ with bus ready
    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign idx    = haddr[11:2];
    assign flagRead = accept && !hwrite && (idx == IDX_FLAGS_A ||
                      idx == IDX_FLAGS_B || idx == IDX_FLAGS_C);

    // Read data for one register index, unused bits zero
    function automatic logic [31:0] readReg(input state_t s,
                                            input logic [9:0] i);
        logic [7:0] b;
        b = 8'h00;
        case (i)
            IDX_TOP_LO:   b = s.bars.topEnd[7:0];         // RL4
            IDX_TOP_HI:   b = s.bars.topEnd[15:8];        // RL3
            IDX_BOT_LO:   b = s.bars.bottomStart[7:0];    // RL5
            IDX_BOT_HI:   b = s.bars.bottomStart[15:8];   // RL5
            IDX_LEFT_LO:  b = s.bars.leftEnd[7:0];        // RL7
            IDX_LEFT_HI:  b = s.bars.leftEnd[15:8];       // RL7
            IDX_RIGHT_LO: b = s.bars.rightStart[7:0];     // RL8
            IDX_RIGHT_HI: b = s.bars.rightStart[15:8];    // RL8
            IDX_FLAGS_A,
            IDX_FLAGS_B,
            IDX_FLAGS_C:  b = {1'b0, s.flags};            // RL9
            IDX_AUD_VER:  b = s.audio.version;
            IDX_AUD_CODE: b = {s.audio.codingKind, 1'b0,
                               s.audio.channelCode};      // RL10 RL11
            IDX_IRQ_STAT: b = {1'b0, s.status};
            IDX_IRQ_MASK: b = {1'b0, s.mask};
            default:      b = 8'h00;                      // RL12
        endcase
        return {24'h000000, b};
    endfunction : readReg

    // ==========================================================
    // Change events: compared fields plus parser pulses
    always_comb begin
        setEvt = changeEvt;                               // RL1
        if (aviValid && aviIn != st_reg.bars) begin
            setEvt[FLAG_AVI] = 1'b1;                      // RL2
        end
        if (audValid && audIn != st_reg.audio) begin
            setEvt[FLAG_AUDIO] = 1'b1;                    // RL2
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.ready = 1'b1;
        // Whole packet captured in one edge
        if (aviValid) begin
            st_next.bars = aviIn;                         // RL13
        end
        if (audValid) begin
            st_next.audio = audIn;                        // RL13
        end
        // Read data latched for the data phase
        if (accept && !hwrite) begin
            st_next.rdata = readReg(st_reg, idx);
        end
        // Any copy read clears all flags; new events win
        st_next.flags = (flagRead ? FLAGS_RESET : st_reg.flags)
                        | setEvt;                         // RL2 RL9
        // Data phase of a write: only status and mask respond
        st_next.status = st_reg.status;
        if (st_reg.wrPend && st_reg.wrIdx == IDX_IRQ_STAT) begin
            st_next.status = st_reg.status & ~hwdata[6:0];
        end
        if (st_reg.wrPend && st_reg.wrIdx == IDX_IRQ_MASK) begin
            st_next.mask = hwdata[6:0];
        end
        st_next.status = st_next.status | setEvt;
        st_next.wrPend = accept && hwrite;                // RL12
        st_next.wrIdx  = idx;
        st_next.irq    = |(st_next.status & st_next.mask);
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg.bars        <= '{FIELD_RESET, FIELD_RESET,
                                    FIELD_RESET, FIELD_RESET};
            st_reg.audio       <= '0;
            st_reg.flags       <= FLAGS_RESET;
            st_reg.status      <= FLAGS_RESET;
            st_reg.mask        <= MASK_RESET;
            st_reg.wrPend      <= 1'b0;
            st_reg.wrIdx       <= '0;
            st_reg.rdata       <= '0;
            st_reg.ready       <= 1'b1;
            st_reg.irq         <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state flip-flops, except hresp, which is tied to OKAY
    assign hrdata    = st_reg.rdata;
    assign hreadyout = st_reg.ready;
    assign hresp     = HRESP_OKAY;
    assign irq       = st_reg.irq;

    // ==========================================================
    // Assertions
    property p_acpFlag;
        @(posedge clk) disable iff (!nrst)
        changeEvt[FLAG_ACP] |=> st_reg.flags[FLAG_ACP];
    endproperty
    a_acpFlag: assert property (p_acpFlag) // RL1
        else $error("ACP change did not set its flag");

    property p_readClears;
        @(posedge clk) disable iff (!nrst)
        (flagRead && setEvt == 7'h00) |=> st_reg.flags == 7'h00;
    endproperty
    a_readClears: assert property (p_readClears) // RL2
        else $error("flag read did not clear flags");

    property p_topHigh;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_TOP_HI) |=>
            hrdata == {24'h000000, $past(st_reg.bars.topEnd[15:8])};
    endproperty
    a_topHigh: assert property (p_topHigh) // RL3
        else $error("top bar upper byte wrong");

    property p_botLow;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_BOT_LO) |=>
            hrdata == {24'h000000, $past(st_reg.bars.bottomStart[7:0])};
    endproperty
    a_botLow: assert property (p_botLow) // RL5
        else $error("bottom bar lower byte wrong");

    property p_leftHigh;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_LEFT_HI) |=>
            hrdata == {24'h000000, $past(st_reg.bars.leftEnd[15:8])};
    endproperty
    a_leftHigh: assert property (p_leftHigh) // RL7
        else $error("left pillar upper byte wrong");

    property p_rightLow;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_RIGHT_LO) |=>
            hrdata == {24'h000000, $past(st_reg.bars.rightStart[7:0])};
    endproperty
    a_rightLow: assert property (p_rightLow) // RL8
        else $error("right pillar lower byte wrong");

    property p_flagCopy;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_FLAGS_B) |=>
            hrdata == {25'h0000000, $past(st_reg.flags)};
    endproperty
    a_flagCopy: assert property (p_flagCopy) // RL9
        else $error("flag copy read wrong");

    property p_audioCode;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_AUD_CODE) |=>
            hrdata[7:4] == $past(st_reg.audio.codingKind)
            && hrdata[2:0] == $past(st_reg.audio.channelCode)
            && hrdata[3] == 1'b0;
    endproperty
    a_audioCode: assert property (p_audioCode) // RL10 RL11
        else $error("audio coding byte wrong");

    property p_writeIgnored;
        @(posedge clk) disable iff (!nrst)
        (accept && hwrite && !aviValid) ##1 !aviValid |=>
            $stable(st_reg.bars);
    endproperty
    a_writeIgnored: assert property (p_writeIgnored) // RL12
        else $error("write altered captured fields");

    property p_atomic;
        @(posedge clk) disable iff (!nrst)
        aviValid |=> st_reg.bars == $past(aviIn);
    endproperty
    a_atomic: assert property (p_atomic) // RL13
        else $error("bar fields not captured together");

    property p_audAtomic;
        @(posedge clk) disable iff (!nrst)
        audValid |=> st_reg.audio == $past(audIn);
    endproperty
    a_audAtomic: assert property (p_audAtomic) // RL13
        else $error("audio fields not captured together");

    property p_topLow;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_TOP_LO) |=>
            hrdata == {24'h000000, $past(st_reg.bars.topEnd[7:0])};
    endproperty
    a_topLow: assert property (p_topLow) // RL4
        else $error("top bar lower byte wrong");

    property p_botHigh;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_BOT_HI) |=>
            hrdata == {24'h000000, $past(st_reg.bars.bottomStart[15:8])};
    endproperty
    a_botHigh: assert property (p_botHigh) // RL5
        else $error("bottom bar upper byte wrong");

    property p_leftLow;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_LEFT_LO) |=>
            hrdata == {24'h000000, $past(st_reg.bars.leftEnd[7:0])};
    endproperty
    a_leftLow: assert property (p_leftLow) // RL7
        else $error("left pillar lower byte wrong");

    property p_rightHigh;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_RIGHT_HI) |=>
            hrdata == {24'h000000, $past(st_reg.bars.rightStart[15:8])};
    endproperty
    a_rightHigh: assert property (p_rightHigh) // RL8
        else $error("right pillar upper byte wrong");

    property p_flagCopyA;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_FLAGS_A) |=>
            hrdata == {25'h0, $past(st_reg.flags)};
    endproperty
    a_flagCopyA: assert property (p_flagCopyA) // RL2
        else $error("first flag copy read wrong");

    property p_flagCopyC;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_FLAGS_C) |=>
            hrdata == {25'h0, $past(st_reg.flags)};
    endproperty
    a_flagCopyC: assert property (p_flagCopyC) // RL2
        else $error("third flag copy read wrong");

    property p_audioVer;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx == IDX_AUD_VER) |=>
            hrdata == {24'h000000, $past(st_reg.audio.version)};
    endproperty
    a_audioVer: assert property (p_audioVer) // RL12
        else $error("audio version byte wrong");

    property p_unmapped;
        @(posedge clk) disable iff (!nrst)
        (accept && !hwrite && idx > IDX_IRQ_MASK) |=> hrdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) // RL12
        else $error("unmapped read not zero");

    property p_aviFlag;
        @(posedge clk) disable iff (!nrst)
        (aviValid && aviIn != st_reg.bars) |=> st_reg.flags[FLAG_AVI];
    endproperty
    a_aviFlag: assert property (p_aviFlag) // RL2
        else $error("video change did not set its flag");

    property p_audFlag;
        @(posedge clk) disable iff (!nrst)
        (audValid && audIn != st_reg.audio) |=> st_reg.flags[FLAG_AUDIO];
    endproperty
    a_audFlag: assert property (p_audFlag) // RL2
        else $error("audio change did not set its flag");

    property p_statusSetWins;
        @(posedge clk) disable iff (!nrst)
        (st_reg.wrPend && st_reg.wrIdx == IDX_IRQ_STAT) |=>
            (st_reg.status & $past(changeEvt)) == $past(changeEvt);
    endproperty
    a_statusSetWins: assert property (p_statusSetWins) // RL1
        else $error("status clear dropped a new event");

    property p_irqLevel;
        @(posedge clk) disable iff (!nrst)
        irq == |(st_reg.status & st_reg.mask);
    endproperty
    a_irqLevel: assert property (p_irqLevel) // RL1
        else $error("interrupt level wrong");

    property p_readyOkay;
        @(posedge clk) disable iff (!nrst)
        hreadyout && hresp == HRESP_OKAY;
    endproperty
    a_readyOkay: assert property (p_readyOkay) // RL12
        else $error("bus not ready or response not okay");

endmodule : infoframe_readback_bank

`default_nettype wire

// [src/infoframe_readback_pkg.sv]
// Purpose: Shared constants and types of the infoframe readback bank
// Assumes: 32-bit AHB-Lite data, one register per aligned word
// Notes:   Register indices sit at byte address index * 4
package infoframe_readback_pkg;

    // ==========================================================
    // Register indices (byte address = index * 4)
    localparam logic [9:0] IDX_TOP_LO    = 10'h086;
    localparam logic [9:0] IDX_FLAGS_A   = 10'h087;
    localparam logic [9:0] IDX_TOP_HI    = 10'h088;
    localparam logic [9:0] IDX_BOT_LO    = 10'h089;
    localparam logic [9:0] IDX_BOT_HI    = 10'h08a;
    localparam logic [9:0] IDX_LEFT_LO   = 10'h08b;
    localparam logic [9:0] IDX_LEFT_HI   = 10'h08c;
    localparam logic [9:0] IDX_RIGHT_LO  = 10'h08d;
    localparam logic [9:0] IDX_RIGHT_HI  = 10'h08e;
    localparam logic [9:0] IDX_FLAGS_B   = 10'h08f;
    localparam logic [9:0] IDX_AUD_VER   = 10'h090;
    localparam logic [9:0] IDX_AUD_CODE  = 10'h091;
    localparam logic [9:0] IDX_FLAGS_C   = 10'h097;
    localparam logic [9:0] IDX_IRQ_STAT  = 10'h0a0;
    localparam logic [9:0] IDX_IRQ_MASK  = 10'h0a1;

    // ==========================================================
    // Change flag bit positions
    localparam int FLAG_AVI   = 0;
    localparam int FLAG_AUDIO = 1;
    localparam int FLAG_SPD   = 2;
    localparam int FLAG_MPEG  = 3;
    localparam int FLAG_ACP   = 4;
    localparam int FLAG_ISRC1 = 5;
    localparam int FLAG_ISRC2 = 6;
    localparam int NUM_FLAGS  = 7;

    // ==========================================================
    // AHB-Lite encodings and reset values
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;
    localparam logic [6:0] FLAGS_RESET   = 7'h00;
    localparam logic [6:0] MASK_RESET    = 7'h00;
    localparam logic [15:0] FIELD_RESET  = 16'h0000;

    // ==========================================================
    // Captured packet contents
    typedef struct packed {
        logic [15:0] topEnd;
        logic [15:0] bottomStart;
        logic [15:0] leftEnd;
        logic [15:0] rightStart;
    } bars_t;

    typedef struct packed {
        logic [7:0] version;
        logic [3:0] codingKind;
        logic [2:0] channelCode;
    } audio_t;

    // Whole state of the bank
    typedef struct packed {
        bars_t       bars;
        audio_t      audio;
        logic [6:0]  flags;
        logic [6:0]  status;
        logic [6:0]  mask;
        logic        wrPend;
        logic [9:0]  wrIdx;
        logic [31:0] rdata;
        logic        ready;
        logic        irq;
    } state_t;

endpackage : infoframe_readback_pkg

// [test/packet_source.sv]
// Purpose: Packet source model feeding the bank
// Assumes: Pulses last one clk cycle
// Notes:   Data lines scrambled outside pulses
`timescale 1ns/1ps
`default_nettype none
module packet_source
    import infoframe_readback_pkg::*;
(
    input  wire logic                           clk,
    output var logic                            aviValid,
    output var infoframe_readback_pkg::bars_t   aviIn,
    output var logic                            audValid,
    output var infoframe_readback_pkg::audio_t  audIn,
    output var logic [6:0]                      changeEvt
);
    import infoframe_readback_pkg::*;
    // ==========================================================
    // Idle lines at time zero
    initial begin
        aviValid  = 1'b0;
        aviIn     = '0;
        audValid  = 1'b0;
        audIn     = '0;
        changeEvt = 7'h00;
    end
    // One video packet, then stale lines inverted
    task automatic sendAvi(input bars_t b);
        @(posedge clk);
        aviIn    <= b;
        aviValid <= 1'b1;
        @(posedge clk);
        aviIn    <= ~b;
        aviValid <= 1'b0;
    endtask : sendAvi
    // One audio packet
    task automatic sendAud(input audio_t a);
        @(posedge clk);
        audIn    <= a;
        audValid <= 1'b1;
        @(posedge clk);
        audIn    <= ~a;
        audValid <= 1'b0;
    endtask : sendAud
    // Change pulse on chosen packet types
    task automatic pulseEvt(input logic [6:0] e);
        @(posedge clk);
        changeEvt <= e;
        @(posedge clk);
        changeEvt <= 7'h00;
    endtask : pulseEvt
endmodule : packet_source
`default_nettype wire

// [test/infoframe_readback_bank_tb.sv]
// Purpose: Register-level test of the readback bank
// Assumes: Zero wait AHB-Lite slave
// Notes:   Byte address is index times four
`timescale 1ns/1ps
`default_nettype none
module infoframe_readback_bank_tb;
    import infoframe_readback_pkg::*;
    logic        clk, nrst, hsel, hwrite, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        aviValid, audValid;
    bars_t       aviIn;
    audio_t      audIn;
    logic [6:0]  changeEvt;
    logic [9:0]  cp [3] = '{IDX_FLAGS_A, IDX_FLAGS_B, IDX_FLAGS_C};
    int          n_errors = 0, n_tests = 0, cycles = 0, k;
    // ==========================================================
    // Design and packet source
    infoframe_readback_bank DUT (.clk(clk), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .aviValid(aviValid),
        .aviIn(aviIn), .audValid(audValid), .audIn(audIn),
        .changeEvt(changeEvt), .irq(irq));
    packet_source src (.clk(clk), .aviValid(aviValid), .aviIn(aviIn),
        .audValid(audValid), .audIn(audIn), .changeEvt(changeEvt));
    // ==========================================================
    // Clock and hang limit
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            summarize();
        end
    end
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    // One single AHB-Lite transfer
    task automatic ahb(input logic w, input logic [9:0] i,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, i, 2'b00};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : ahb
    task automatic rd(input logic [9:0] i, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, i, 32'h0, d);
        check(d, exp);
        check({30'h0, hreadyout, hresp}, {30'h0, 1'b1, HRESP_OKAY});
    endtask : rd
    task automatic wr(input logic [9:0] i, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, i, d, x);
    endtask : wr
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize
    // ==========================================================
    // Main sequence
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        // Cleared state after reset
        rd(IDX_TOP_LO, 32'h0);
        rd(IDX_FLAGS_B, 32'h0);
        rd(10'h0c0, 32'h0);
        $display("Test reset done");
        // Bar fields, bytes from one packet
        src.sendAvi('{16'h1234, 16'hffff, 16'h0000, 16'h0780});
        rd(IDX_TOP_LO, 32'h34);
        rd(IDX_TOP_HI, 32'h12);
        rd(IDX_BOT_LO, 32'hff);
        rd(IDX_BOT_HI, 32'hff);
        rd(IDX_LEFT_LO, 32'h00);
        rd(IDX_LEFT_HI, 32'h00);
        rd(IDX_RIGHT_LO, 32'h80);
        rd(IDX_RIGHT_HI, 32'h07);
        src.sendAvi('{16'h00a5, 16'h0438, 16'h00f0, 16'h0690});
        rd(IDX_BOT_LO, 32'h38);
        rd(IDX_BOT_HI, 32'h04);
        wr(IDX_BOT_LO, 32'hffffffff);
        rd(IDX_BOT_LO, 32'h38);
        $display("Test bars done");
        // Coding kinds 0 to 8, each with a channel code
        for (k = 0; k <= 8; k++) begin
            src.sendAud('{8'(8'h10 + k), 4'(k), 3'(k)});
            rd(IDX_AUD_VER, 32'(8'h10 + k));
            rd(IDX_AUD_CODE, {24'h0, 4'(k), 1'b0, 3'(k)});
        end
        $display("Test audio done");
        // Video and audio changes seen, cleared by one read
        rd(IDX_FLAGS_A, 32'h03);
        rd(IDX_FLAGS_C, 32'h00);
        src.sendAvi('{16'h00a5, 16'h0438, 16'h00f0, 16'h0690});
        rd(IDX_FLAGS_B, 32'h00);
        for (k = 0; k < 7; k++) begin
            src.pulseEvt(7'(1 << k));
            rd(cp[k % 3], 32'(1 << k));
            rd(cp[(k + 1) % 3], 32'h0);
        end
        $display("Test flags done");
        // Interrupt raised, masked and cleared
        // Clear of all status bits while a new event lands
        fork
            wr(IDX_IRQ_STAT, 32'h7f);
            begin
                @(posedge clk);
                src.pulseEvt(7'h08);
            end
        join
        rd(IDX_IRQ_STAT, 32'h08);
        wr(IDX_IRQ_STAT, 32'h08);
        rd(IDX_IRQ_STAT, 32'h0);
        src.pulseEvt(7'h10);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(IDX_IRQ_STAT, 32'h10);
        wr(IDX_IRQ_MASK, 32'h10);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        rd(IDX_IRQ_MASK, 32'h10);
        wr(IDX_IRQ_STAT, 32'h10);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(IDX_IRQ_STAT, 32'h0);
        $display("Test interrupt done");
        summarize();
    end
endmodule : infoframe_readback_bank_tb
`default_nettype wire
